// >>> rtl/asc_pkg.sv
/*
 * asc_pkg: register map, field positions, reset values and carrier types
 * for the serial port control and enable block.
 * assumes: 8-bit register port, byte offsets as printed, one clock domain.
 */
// Contract
// - alternative control registers at 0x1, 0x2; access only with alternate map set
// - alt enable bit 7 gates edge seen flag onto interrupt
// - alt enable bit 1 gates bit mismatch flag onto interrupt
// - alt enable bit 0 gates break seen flag onto interrupt
// - mismatch mode 00 off, 01 sample tick 9, 10 tick 13, 11 reserved
// - alt error control bit 0 switches break detector on
// - main control two at 0x3, readable and writable any time
// - bit 7 lets transmit holding empty raise interrupt
// - bit 6 lets transmission done raise interrupt
// - bit 5 lets receive full or overrun raise interrupt
// - bit 4 lets idle line raise interrupt
// - bit 3 turns transmitter on and takes the transmit pin
// - raising the transmitter enable queues one idle preamble
// - bit 2 turns receiver on
// - bit 1 puts receiver in standby, blocks its interrupts, hardware clears; edge seen and break seen flags still raise interrupt here
// - a short pulse on send break sends exactly one break character
// - send break held high sends whole break characters back to back
// - edge seen on active receive edge per polarity, write one clears
// - mismatch flag when sampled receive differs from sent bit, write one clears
// - break seen flag on received break when detector on, write one clears
// - frame length bit picks eight or nine data bits, sets break length
package asc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [7:0] OFS_ALT_STATUS = 8'h00;
	localparam logic [7:0] OFS_ALT_IRQ_EN = 8'h01;
	localparam logic [7:0] OFS_ALT_ERR_CTRL = 8'h02;
	localparam logic [7:0] OFS_MAIN_CTRL2 = 8'h03;
	localparam logic [7:0] OFS_LINE_OPTIONS = 8'h08;

	// alternative status bits
	localparam int BIT_EDGE_FLAG = 7;
	localparam int BIT_MISMATCH_VAL = 2;
	localparam int BIT_MISMATCH_FLAG = 1;
	localparam int BIT_BREAK_FLAG = 0;
	// alternative enable bits
	localparam int BIT_EDGE_IE = 7;
	localparam int BIT_MISMATCH_IE = 1;
	localparam int BIT_BREAK_IE = 0;
	// alternative error control
	localparam int BIT_MODE_HI = 2;
	localparam int BIT_MODE_LO = 1;
	localparam int BIT_BREAK_DET_ON = 0;
	// line options
	localparam int BIT_NINE_BITS = 0;
	localparam int BIT_LONG_BREAK = 1;
	localparam int BIT_RX_POL = 2;
	localparam int BIT_ALT_MAP = 3;

	localparam logic [7:0] RST_ALT_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_ALT_ERR_CTRL = 8'h00;
	localparam logic [7:0] RST_LINE_OPTIONS = 8'h00;

	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_TICK9 = 2'h1;
	localparam logic [1:0] MODE_TICK13 = 2'h2;

	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_NINTH = 4'h8;
	localparam logic [3:0] TICK_THIRTEENTH = 4'hC;
	localparam logic [3:0] FRAME_BITS_SHORT = 4'hA;
	localparam logic [3:0] LONG_BREAK_EXTRA = 4'h3;
	localparam logic [7:0] TICKS_PER_BIT = 8'h10;

	typedef struct packed {
		logic tx_empty_irq_enable;
		logic tx_done_irq_enable;
		logic rx_full_irq_enable;
		logic line_idle_irq_enable;
		logic transmitter_on;
		logic receiver_on;
		logic receiver_standby;
		logic send_break_request;
	} asc_ctrl2_s;

	localparam asc_ctrl2_s RST_MAIN_CTRL2 = 8'h00;

	typedef struct packed {
		logic tx_holding_empty_flag;
		logic tx_done_flag;
		logic rx_holding_full_flag;
		logic overrun_flag;
		logic line_idle_flag;
	} asc_flags_s;

	typedef enum logic [2:0] {
		ASC_IDLE = 3'b001,
		ASC_PREAMBLE = 3'b010,
		ASC_BREAK = 3'b100
	} asc_tx_state_e;

endpackage : asc_pkg

// >>> rtl/asc_control.sv
/*
 * asc_control: control and interrupt enable registers of the serial port,
 * idle preamble and break generation, receive edge, bit mismatch and break
 * detection, and the combined interrupt request.
 * assumes: receive status flags come from logic on clk_i; sample_tick_i is
 * a one-cycle pulse at sixteen times the bit rate; the data shifter drives
 * tx_data_i and holds off while line_busy_o is high.
 */
// Our own choice: strobed register access.
`timescale 1ns/100ps
module asc_control (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [asc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [asc_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [asc_pkg::DATA_W-1:0] rdata_o,
	input wire asc_pkg::asc_flags_s flags_i,
	input wire logic wakeup_i,
	input wire logic sample_tick_i,
	input wire logic tx_active_i,
	input wire logic tx_data_i,
	input wire logic rx_pin_i,
	output logic txd_o,
	output logic txd_oe_n_o,
	output logic line_busy_o,
	output logic bit_strobe_o,
	output logic transmitter_on_o,
	output logic receiver_on_o,
	output logic receiver_standby_o,
	output logic irq_o
);

	logic [7:0] alt_interrupt_enable_reg;
	logic [7:0] alt_error_control_reg;
	logic [7:0] line_options_reg;
	asc_pkg::asc_ctrl2_s main_control_two_reg;
	logic edge_seen_flag_reg;
	logic bit_mismatch_flag_reg;
	logic mismatch_value_reg;
	logic break_seen_flag_reg;
	logic [2:0] rx_sync_reg;
	logic rx_filt_reg;
	logic rx_prev_reg;
	logic [3:0] tick_reg;
	logic [3:0] bit_cnt_reg;
	logic break_pend_reg;
	logic preamble_pend_reg;
	logic [7:0] low_ticks_reg;
	logic [3:0] low_bits_reg;
	logic break_armed_reg;
	asc_pkg::asc_tx_state_e state_reg;
	asc_pkg::asc_tx_state_e state_next;

	logic alt_map;
	logic wr_alt;
	logic bit_end;
	logic [3:0] frame_bits;
	logic [3:0] break_bits;
	logic rx_norm;
	logic edge_set;
	logic mismatch_set;
	logic break_set;
	logic sample_now;
	logic sending;
	logic any_irq;

	assign alt_map = line_options_reg[asc_pkg::BIT_ALT_MAP];
	assign wr_alt = wr_i && alt_map;
	assign bit_end = sample_tick_i && (tick_reg == asc_pkg::TICK_LAST);
	assign frame_bits = asc_pkg::FRAME_BITS_SHORT
		+ {3'h0, line_options_reg[asc_pkg::BIT_NINE_BITS]};
	assign break_bits = line_options_reg[asc_pkg::BIT_LONG_BREAK]
		? frame_bits + asc_pkg::LONG_BREAK_EXTRA : frame_bits;
	// normalised so that the idle level is always high
	assign rx_norm = rx_filt_reg ^ line_options_reg[asc_pkg::BIT_RX_POL];

	// register writes
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			alt_interrupt_enable_reg <= asc_pkg::RST_ALT_IRQ_EN;
			alt_error_control_reg <= asc_pkg::RST_ALT_ERR_CTRL;
			line_options_reg <= asc_pkg::RST_LINE_OPTIONS;
		end else begin
			if (wr_alt && addr_i == asc_pkg::OFS_ALT_IRQ_EN) begin
				alt_interrupt_enable_reg <= wdata_i;
			end
			if (wr_alt && addr_i == asc_pkg::OFS_ALT_ERR_CTRL) begin
				alt_error_control_reg <= wdata_i;
			end
			if (wr_i && addr_i == asc_pkg::OFS_LINE_OPTIONS) begin
				line_options_reg <= wdata_i;
			end
		end
	end

	// standby: the wakeup pulse wins over a software write in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			main_control_two_reg <= asc_pkg::RST_MAIN_CTRL2;
		end else begin
			if (wr_i && addr_i == asc_pkg::OFS_MAIN_CTRL2) begin
				main_control_two_reg <= wdata_i;
			end
			if (wakeup_i) begin
				main_control_two_reg.receiver_standby <= 1'b0;
			end
		end
	end

	// receive pin: three flops, a change counts once stages two and three agree
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_sync_reg <= 3'h7;
			rx_filt_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_sync_reg <= {rx_sync_reg[1:0], rx_pin_i};
			if (rx_sync_reg[1] == rx_sync_reg[2]) begin
				rx_filt_reg <= rx_sync_reg[2];
			end
			rx_prev_reg <= rx_filt_reg;
		end
	end

	// judged on the pin level, so a polarity change alone flags nothing
	assign edge_set = (rx_prev_reg != rx_filt_reg)
		&& (rx_filt_reg == line_options_reg[asc_pkg::BIT_RX_POL]);

	// bit tick phase, shared with the data shifter through bit_strobe_o
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_reg <= 4'h0;
			bit_strobe_o <= 1'b0;
		end else begin
			if (sample_tick_i) begin
				tick_reg <= tick_reg + 4'h1;
			end
			bit_strobe_o <= bit_end;
		end
	end

	// break and preamble requests are latched so a short pulse is not missed
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			break_pend_reg <= 1'b0;
			preamble_pend_reg <= 1'b0;
		end else begin
			if (state_reg == asc_pkg::ASC_BREAK) begin
				break_pend_reg <= 1'b0;
			end
			if (wr_i && addr_i == asc_pkg::OFS_MAIN_CTRL2 && wdata_i[0]) begin
				break_pend_reg <= 1'b1;
			end
			if (!main_control_two_reg.transmitter_on) begin
				preamble_pend_reg <= 1'b0;
			end else if (state_reg == asc_pkg::ASC_PREAMBLE) begin
				preamble_pend_reg <= 1'b0;
			end
			if (wr_i && addr_i == asc_pkg::OFS_MAIN_CTRL2 && wdata_i[3]
				&& !main_control_two_reg.transmitter_on) begin
				preamble_pend_reg <= 1'b1;
			end
		end
	end

	// break and preamble sequencer, switching on bit boundaries, or to idle at once when the transmitter goes off
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			asc_pkg::ASC_IDLE: begin
				if (bit_end && !tx_active_i) begin
					if (break_pend_reg || main_control_two_reg.send_break_request) begin
						state_next = asc_pkg::ASC_BREAK;
					end else if (preamble_pend_reg) begin
						state_next = asc_pkg::ASC_PREAMBLE;
					end
				end
			end
			asc_pkg::ASC_PREAMBLE: begin
				if (bit_end && bit_cnt_reg == frame_bits - 4'h1) begin
					state_next = asc_pkg::ASC_IDLE;
				end
			end
			asc_pkg::ASC_BREAK: begin
				if (bit_end && bit_cnt_reg == break_bits - 4'h1
					&& !main_control_two_reg.send_break_request) begin
					state_next = preamble_pend_reg ? asc_pkg::ASC_PREAMBLE
						: asc_pkg::ASC_IDLE;
				end
			end
			default: begin
				state_next = asc_pkg::ASC_IDLE;
			end
		endcase
		if (!main_control_two_reg.transmitter_on) begin
			state_next = asc_pkg::ASC_IDLE;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= asc_pkg::ASC_IDLE;
			bit_cnt_reg <= 4'h0;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg) begin
				bit_cnt_reg <= 4'h0;
			end else if (bit_end && state_reg == asc_pkg::ASC_BREAK
				&& bit_cnt_reg == break_bits - 4'h1) begin
				bit_cnt_reg <= 4'h0;
			end else if (bit_end) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// transmit pin; released while the transmitter is off
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			txd_o <= 1'b1;
			txd_oe_n_o <= 1'b1;
			line_busy_o <= 1'b0;
		end else begin
			txd_oe_n_o <= !main_control_two_reg.transmitter_on;
			line_busy_o <= state_next != asc_pkg::ASC_IDLE;
			unique case (state_next)
				asc_pkg::ASC_BREAK: txd_o <= 1'b0;
				asc_pkg::ASC_PREAMBLE: txd_o <= 1'b1;
				default: txd_o <= tx_active_i ? tx_data_i : 1'b1;
			endcase
		end
	end

	// mismatch check: sample point chosen by mode, reserved code checks nothing
	always_comb begin
		unique case (alt_error_control_reg[asc_pkg::BIT_MODE_HI:asc_pkg::BIT_MODE_LO])
			asc_pkg::MODE_TICK9: sample_now = tick_reg == asc_pkg::TICK_NINTH;
			asc_pkg::MODE_TICK13: sample_now = tick_reg == asc_pkg::TICK_THIRTEENTH;
			default: sample_now = 1'b0;
		endcase
	end

	assign sending = main_control_two_reg.transmitter_on && !txd_oe_n_o
		&& (state_reg != asc_pkg::ASC_IDLE || tx_active_i);
	assign mismatch_set = sending && sample_tick_i && sample_now
		&& (rx_filt_reg != txd_o);

	// received break: a whole frame of low bits, flagged once per low stretch
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_ticks_reg <= 8'h00;
			low_bits_reg <= 4'h0;
			break_armed_reg <= 1'b1;
		end else begin
			if (rx_norm) begin
				low_ticks_reg <= 8'h00;
				low_bits_reg <= 4'h0;
				break_armed_reg <= 1'b1;
			end else if (sample_tick_i) begin
				if (low_ticks_reg == asc_pkg::TICKS_PER_BIT - 8'h01) begin
					low_ticks_reg <= 8'h00;
					if (low_bits_reg != frame_bits) begin
						low_bits_reg <= low_bits_reg + 4'h1;
					end
				end else begin
					low_ticks_reg <= low_ticks_reg + 8'h01;
				end
			end
			if (break_set) begin
				break_armed_reg <= 1'b0;
			end
		end
	end

	assign break_set = alt_error_control_reg[asc_pkg::BIT_BREAK_DET_ON]
		&& break_armed_reg && !rx_norm && low_bits_reg == frame_bits;

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			edge_seen_flag_reg <= 1'b0;
			bit_mismatch_flag_reg <= 1'b0;
			mismatch_value_reg <= 1'b0;
			break_seen_flag_reg <= 1'b0;
		end else begin
			if (wr_alt && addr_i == asc_pkg::OFS_ALT_STATUS) begin
				if (wdata_i[asc_pkg::BIT_EDGE_FLAG]) begin
					edge_seen_flag_reg <= 1'b0;
				end
				if (wdata_i[asc_pkg::BIT_MISMATCH_FLAG]) begin
					bit_mismatch_flag_reg <= 1'b0;
				end
				if (wdata_i[asc_pkg::BIT_BREAK_FLAG]) begin
					break_seen_flag_reg <= 1'b0;
				end
			end
			if (edge_set) begin
				edge_seen_flag_reg <= 1'b1;
			end
			if (mismatch_set) begin
				bit_mismatch_flag_reg <= 1'b1;
				mismatch_value_reg <= rx_filt_reg;
			end
			if (break_set) begin
				break_seen_flag_reg <= 1'b1;
			end
		end
	end

	// standby silences only the receive full, overrun and idle line sources
	always_comb begin
		any_irq = 1'b0;
		if (alt_interrupt_enable_reg[asc_pkg::BIT_EDGE_IE] && edge_seen_flag_reg) begin
			any_irq = 1'b1;
		end
		if (alt_interrupt_enable_reg[asc_pkg::BIT_MISMATCH_IE]
			&& bit_mismatch_flag_reg) begin
			any_irq = 1'b1;
		end
		if (alt_interrupt_enable_reg[asc_pkg::BIT_BREAK_IE] && break_seen_flag_reg) begin
			any_irq = 1'b1;
		end
		if (main_control_two_reg.tx_empty_irq_enable
			&& flags_i.tx_holding_empty_flag) begin
			any_irq = 1'b1;
		end
		if (main_control_two_reg.tx_done_irq_enable && flags_i.tx_done_flag) begin
			any_irq = 1'b1;
		end
		if (main_control_two_reg.rx_full_irq_enable
			&& !main_control_two_reg.receiver_standby
			&& (flags_i.rx_holding_full_flag || flags_i.overrun_flag)) begin
			any_irq = 1'b1;
		end
		if (main_control_two_reg.line_idle_irq_enable
			&& !main_control_two_reg.receiver_standby
			&& flags_i.line_idle_flag) begin
			any_irq = 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			transmitter_on_o <= 1'b0;
			receiver_on_o <= 1'b0;
			receiver_standby_o <= 1'b0;
		end else begin
			irq_o <= any_irq;
			transmitter_on_o <= main_control_two_reg.transmitter_on;
			receiver_on_o <= main_control_two_reg.receiver_on;
			receiver_standby_o <= main_control_two_reg.receiver_standby;
		end
	end

	// read port: data in the cycle after the strobe, alternative map gated
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			unique case (addr_i)
				asc_pkg::OFS_ALT_STATUS: rdata_o <= alt_map ? {edge_seen_flag_reg,
					4'h0, mismatch_value_reg, bit_mismatch_flag_reg,
					break_seen_flag_reg} : 8'h00;
				asc_pkg::OFS_ALT_IRQ_EN: rdata_o <= alt_map
					? (alt_interrupt_enable_reg & 8'h83) : 8'h00;
				asc_pkg::OFS_ALT_ERR_CTRL: rdata_o <= alt_map
					? (alt_error_control_reg & 8'h07) : 8'h00;
				asc_pkg::OFS_MAIN_CTRL2: rdata_o <= main_control_two_reg;
				asc_pkg::OFS_LINE_OPTIONS: rdata_o <= line_options_reg & 8'h0F;
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

endmodule : asc_control

// >>> testbench/asc_control_properties.sv
/*
 * asc_control_properties: port timing checks on the control block.
 * assumes: bound to asc_control; one clock, reset async active high.
 */
`timescale 1ns/100ps
module asc_control_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [asc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [asc_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [asc_pkg::DATA_W-1:0] rdata_o,
	input wire asc_pkg::asc_flags_s flags_i,
	input wire logic wakeup_i,
	input wire logic sample_tick_i,
	input wire logic tx_active_i,
	input wire logic tx_data_i,
	input wire logic rx_pin_i,
	input wire logic txd_o,
	input wire logic txd_oe_n_o,
	input wire logic line_busy_o,
	input wire logic bit_strobe_o,
	input wire logic transmitter_on_o,
	input wire logic receiver_on_o,
	input wire logic receiver_standby_o,
	input wire logic irq_o
);
	// ticks seen while the pin is low; a break must end on a bit boundary
	logic [11:0] low_ticks;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_ticks <= 12'h000;
		end else if (txd_o) begin
			low_ticks <= 12'h000;
		end else if (sample_tick_i) begin
			low_ticks <= low_ticks + 12'h001;
		end
	end
	// tick phase kept apart from the design's own counter
	logic [3:0] phase;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase <= 4'h0;
		end else if (sample_tick_i) begin
			phase <= phase + 4'h1;
		end
	end
	default clocking dcb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside a read answer");
	unmapped_zero_a: assert property (
		rd_i && addr_i > 8'h03 && addr_i != 8'h08 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	alt_en_bits_a: assert property (
		rd_i && addr_i == 8'h01 |=> rdata_o[6:2] == 5'h00)
		else $error("unused enable bits read nonzero");
	alt_err_bits_a: assert property (
		rd_i && addr_i == 8'h02 |=> rdata_o[7:3] == 5'h00)
		else $error("unused error control bits read nonzero");
	ctrl_copy_a: assert property (
		wr_i && addr_i == 8'h03 && !wakeup_i |-> ##2
		{transmitter_on_o, receiver_on_o, receiver_standby_o} ==
		3'($past(wdata_i, 2) >> 1))
		else $error("control copies do not follow the write");
	wake_clear_a: assert property (
		wakeup_i && !wr_i |-> ##2 !receiver_standby_o)
		else $error("wakeup did not clear standby");
	pin_owner_a: assert property (
		$stable(transmitter_on_o) |-> txd_oe_n_o == !transmitter_on_o)
		else $error("pin enable disagrees with transmitter enable");
	busy_low_a: assert property (!txd_o && !tx_active_i |-> line_busy_o)
		else $error("pin low without break in progress");
	break_whole_a: assert property (
		$rose(txd_o) |-> low_ticks != 12'h000 && low_ticks[3:0] == 4'h0)
		else $error("break ended off a bit boundary");
	strobe_on_a: assert property (
		sample_tick_i && phase == 4'hF |=> bit_strobe_o)
		else $error("bit strobe missing after sixteenth tick");
	strobe_off_a: assert property (
		!(sample_tick_i && phase == 4'hF) |=> !bit_strobe_o)
		else $error("bit strobe off the sixteenth tick");
endmodule : asc_control_properties

bind asc_control asc_control_properties i_asc_control_properties (
	.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .flags_i(flags_i),
	.wakeup_i(wakeup_i), .sample_tick_i(sample_tick_i),
	.tx_active_i(tx_active_i), .tx_data_i(tx_data_i), .rx_pin_i(rx_pin_i),
	.txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o), .line_busy_o(line_busy_o),
	.bit_strobe_o(bit_strobe_o), .transmitter_on_o(transmitter_on_o),
	.receiver_on_o(receiver_on_o), .receiver_standby_o(receiver_standby_o),
	.irq_o(irq_o));

// >>> testbench/asc_remote_node.sv
/*
 * asc_remote_node: far serial node; holds its line low on command and
 * counts ticks in which the transmit line is low.
 * assumes: tick_i is the same tick that paces the block.
 */
`timescale 1ns/100ps
module asc_remote_node (
	input wire logic clk_i,
	input wire logic tick_i,
	input wire logic txd_i,
	input wire logic txd_oe_n_i,
	input wire logic hold_low_i,
	input wire logic clear_i,
	output logic rx_o,
	output logic [15:0] low_ticks_o
);
	logic line;
	// a released pin sits at the pull-up level, never a stale value
	assign line = txd_oe_n_i ? 1'b1 : txd_i;
	// pulled-up receive line, low only while commanded
	assign rx_o = !hold_low_i;
	always_ff @(posedge clk_i) begin
		if (clear_i) begin
			low_ticks_o <= 16'h0000;
		end else if (tick_i && !line) begin
			low_ticks_o <= low_ticks_o + 16'h0001;
		end
	end
endmodule : asc_remote_node

// >>> testbench/tb_asc_control.sv
/*
 * tb_asc_control: register level tests of the control block with a far
 * node model on the pins.
 * assumes: sample tick every second clock; data shifter held idle.
 */
`timescale 1ns/100ps
module tb_asc_control;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	asc_pkg::asc_flags_s flags_i = '0;
	logic wakeup_i = 1'b0;
	logic sample_tick_i = 1'b0;
	logic hold_low = 1'b0;
	logic clr_cnt = 1'b1;
	logic [7:0] rdata_o;
	logic rx_pin_i, txd_o, txd_oe_n_o, line_busy_o, irq_o;
	logic transmitter_on_o, receiver_on_o, receiver_standby_o;
	logic [15:0] low_ticks;
	int n_mismatch = 0;
	int n_tests = 0;
	int busy_ticks = 0;
	int k;
	// 10, 11, 13 and 14 bits of 16 ticks
	logic [15:0] brk_len [4] = '{16'h00A0, 16'h00B0, 16'h00D0, 16'h00E0};
	logic [7:0] irq_en [5] = '{8'h10, 8'h20, 8'h20, 8'h40, 8'h80};
	always #12.5 clk_i = !clk_i;
	always @(posedge clk_i) sample_tick_i <= !sample_tick_i;
	always @(posedge clk_i) busy_ticks += (line_busy_o === 1'b1) && sample_tick_i;
	// data shifter kept idle: only break and preamble reach the pin
	asc_control i_asc_control (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.flags_i(flags_i), .wakeup_i(wakeup_i), .sample_tick_i(sample_tick_i),
		.tx_active_i(1'b0), .tx_data_i(1'b1), .rx_pin_i(rx_pin_i),
		.txd_o(txd_o), .txd_oe_n_o(txd_oe_n_o), .line_busy_o(line_busy_o),
		.bit_strobe_o(), .transmitter_on_o(transmitter_on_o),
		.receiver_on_o(receiver_on_o), .receiver_standby_o(receiver_standby_o),
		.irq_o(irq_o));
	asc_remote_node i_asc_remote_node (.clk_i(clk_i), .tick_i(sample_tick_i),
		.txd_i(txd_o), .txd_oe_n_i(txd_oe_n_o), .hold_low_i(hold_low),
		.clear_i(clr_cnt), .rx_o(rx_pin_i), .low_ticks_o(low_ticks));
	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk($sformatf("rdata at %h", a), {8'h00, exp}, {8'h00, rdata_o});
	endtask : rd
	task automatic irq_is(input logic exp);
		repeat (2) @(posedge clk_i);
		#1;
		chk("irq", {15'h0000, exp}, {15'h0000, irq_o});
	endtask : irq_is
	// break then optional hold of send-break until hold ticks are seen
	task automatic run_break(input logic [7:0] ctrl, input logic [15:0] hold);
		int n;
		n = 0;
		clr_cnt <= 1'b1;
		busy_ticks = 0;
		wr(8'h03, ctrl);
		clr_cnt <= 1'b0;
		while (low_ticks < hold && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		wr(8'h03, 8'h08);
		while (line_busy_o !== 1'b1 && n < 2200) begin
			@(posedge clk_i);
			n++;
		end
		while (line_busy_o === 1'b1 && n < 8000) begin
			@(posedge clk_i);
			n++;
		end
		#1;
		chk("line busy", 16'h0000, {15'h0000, line_busy_o});
	endtask : run_break
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (40000) @(posedge clk_i);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h03, 8'h00);
		chk("pin enable", 16'h0001, {15'h0000, txd_oe_n_o});
		$display("test reset done");
		rd(8'h01, 8'h00);
		wr(8'h01, 8'hFF);
		wr(8'h08, 8'h08);
		rd(8'h01, 8'h00);
		wr(8'h01, 8'hFF);
		rd(8'h01, 8'h83);
		wr(8'h02, 8'hFF);
		rd(8'h02, 8'h07);
		rd(8'h05, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h03, 8'hF6);
		rd(8'h03, 8'hF6);
		chk("rx on", 16'h0001, {15'h0000, receiver_on_o});
		rd(8'h02, 8'h00);
		wr(8'h03, 8'h00);
		wr(8'h08, 8'h08);
		wr(8'h01, 8'h00);
		wr(8'h02, 8'h00);
		$display("test map done");
		for (k = 0; k < 5; k++) begin
			flags_i <= asc_pkg::asc_flags_s'(5'h01 << k);
			wr(8'h03, 8'hF0 & ~irq_en[k]);
			irq_is(1'b0);
			wr(8'h03, irq_en[k]);
			irq_is(1'b1);
		end
		$display("test enables done");
		flags_i <= 5'h04;
		wr(8'h03, 8'h22);
		irq_is(1'b0);
		@(posedge clk_i);
		wakeup_i <= 1'b1;
		@(posedge clk_i);
		wakeup_i <= 1'b0;
		irq_is(1'b1);
		rd(8'h03, 8'h20);
		flags_i <= 5'h00;
		wr(8'h03, 8'h00);
		$display("test standby done");
		for (k = 0; k < 4; k++) begin
			wr(8'h08, 8'h08 | 8'(k));
			run_break(8'h09, 16'h0000);
			chk("break ticks", brk_len[k], low_ticks);
			chk("busy ticks", brk_len[k] + (k == 0 ? 16'h00A0 : 16'h0000),
				16'(busy_ticks));
		end
		chk("pin enable", 16'h0000, {15'h0000, txd_oe_n_o});
		$display("test break done");
		wr(8'h08, 8'h08);
		run_break(8'h09, 16'h012C);
		chk("held break ticks", 16'h0140, low_ticks);
		$display("test held break done");
		wr(8'h01, 8'h81);
		wr(8'h02, 8'h01);
		hold_low <= 1'b1;
		repeat (10) @(posedge clk_i);
		rd(8'h00, 8'h80);
		irq_is(1'b1);
		repeat (400) @(posedge clk_i);
		rd(8'h00, 8'h81);
		hold_low <= 1'b0;
		wr(8'h00, 8'h80);
		rd(8'h00, 8'h01);
		irq_is(1'b1);
		wr(8'h00, 8'h01);
		irq_is(1'b0);
		wr(8'h02, 8'h00);
		hold_low <= 1'b1;
		repeat (400) @(posedge clk_i);
		hold_low <= 1'b0;
		rd(8'h00, 8'h80);
		wr(8'h00, 8'h80);
		wr(8'h08, 8'h0C);
		hold_low <= 1'b1;
		repeat (10) @(posedge clk_i);
		rd(8'h00, 8'h00);
		hold_low <= 1'b0;
		repeat (10) @(posedge clk_i);
		rd(8'h00, 8'h80);
		wr(8'h08, 8'h08);
		$display("test receive line done");
		wr(8'h01, 8'h00);
		for (k = 0; k < 3; k++) begin
			wr(8'h02, 8'(k << 1));
			wr(8'h00, 8'h87);
			run_break(8'h09, 16'h0000);
			rd(8'h00, k == 0 ? 8'h00 : 8'h06);
		end
		wr(8'h01, 8'h02);
		irq_is(1'b1);
		wr(8'h00, 8'h02);
		irq_is(1'b0);
		$display("test mismatch done");
		tally_and_finish();
	end
endmodule : tb_asc_control
